//--- dv/lcd_bias_control_test.sv
// self-checking bench for the display bias control block
// assumes shortened timing parameters and the host model on the bus
module lcd_bias_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OFF = 20;
	localparam int DIS = 50;
	localparam int SHT = 30;
	logic        mclk, rst, sclPin, sdaLine, sdaOut, sdaOe;
	logic        posRailEnable, negRailEnable, posShortDet, negShortDet;
	logic        overTemp, overCurrent, uvloDet, pwmOn;
	logic [4:0]  posLevel, negLevel;
	logic        applicationSelect, posRailOn, negRailOn, posDischargeOn;
	logic        negDischargeOn, negCurrentLimit, switchGate;
	logic [7:0]  softClamp;
	logic [31:0] seed = 32'hE4D1;
	int          badCount = 0, totalChecks = 0, cycleCount = 0;

	lcd_bias_control #(.OFF_CYC(OFF), .DISCH_CYC(DIS), .SHORT_CYC(SHT), .SS_STEP(2)) dut (
		.mclk, .rst, .sclPin, .sdaIn(sdaLine), .sdaOut, .sdaOe, .posRailEnable,
		.negRailEnable, .posShortDet, .negShortDet, .overTemp, .overCurrent, .uvloDet,
		.pwmOn, .posLevel, .negLevel, .applicationSelect, .posRailOn, .negRailOn,
		.posDischargeOn, .negDischargeOn, .negCurrentLimit, .switchGate, .softClamp);
	serial_host_model host (.sdaOe, .sclPin, .sdaLine);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycleCount++;
		if (cycleCount == 40000) begin
			badCount++;
			closeOut();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] lvl(input logic [7:0] c);
		return (c > 8'h14) ? 8'h14 : c;
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		totalChecks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			badCount++;
		end
	endtask
	task automatic closeOut();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic reg_wr(input logic [7:0] ra, input logic [7:0] d);
		logic a;
		host.wr(bias_pkg::DEV_ADDR, ra, d, 8'h00, 1, a);
		chk("write ack", 8'h01, 8'(a));
		wait_cyc(3);
	endtask
	task automatic reg_rd(input logic [7:0] ra, output logic [7:0] d);
		logic [7:0] x;
		host.rd(ra, 1, d, x);
		wait_cyc(3);
	endtask
	task automatic set_en(input logic pos, input logic v);
		if (pos)
			posRailEnable = v;
		else
			negRailEnable = v;
	endtask
	// short glitch first, then a real drop counted cycle by cycle
	task automatic rail_off(input logic pos, input logic dis);
		int onCyc, disCyc;
		onCyc = 0;
		disCyc = 0;
		set_en(pos, 1'b0);
		wait_cyc(OFF - 6);
		set_en(pos, 1'b1);
		wait_cyc(6);
		chk("rail after glitch", 8'h01, 8'(pos ? posRailOn : negRailOn));
		set_en(pos, 1'b0);
		repeat (OFF + DIS + 30) begin
			@(negedge mclk);
			onCyc += int'(pos ? posRailOn : negRailOn);
			disCyc += int'(pos ? posDischargeOn : negDischargeOn);
		end
		chk("off delay", 8'h01, 8'(onCyc > OFF && onCyc <= OFF + 6));
		chk("discharge cycles", dis ? 8'(DIS) : 8'h00, 8'(disCyc));
		set_en(pos, 1'b1);
		wait_cyc(10);
	endtask
	task automatic fault(input logic uv);
		if (uv)
			uvloDet = 1'b1;
		else
			overTemp = 1'b1;
		wait_cyc(8);
		chk("fault rails", 8'h00, 8'({posRailOn, negRailOn}));
		uvloDet = 1'b0;
		overTemp = 1'b0;
		wait_cyc(10);
		chk("fault recovery", 8'h03, 8'({posRailOn, negRailOn}));
	endtask

	initial begin
		logic [7:0] d, e, code;
		logic       a;
		logic [7:0] ctrlVals [5];
		ctrlVals = '{8'hBC, 8'h00, 8'h01, 8'h02, 8'h43};
		{posRailEnable, negRailEnable, posShortDet, negShortDet} = 4'h0;
		{overTemp, overCurrent, uvloDet, pwmOn} = 4'h0;
		rst = 1'b1;
		wait_cyc(6);
		rst = 1'b0;
		wait_cyc(4);
		chk("posLevel", 8'h0A, 8'(posLevel));
		chk("applicationSelect", 8'h01, 8'(applicationSelect));
		chk("sdaOut", 8'h00, 8'(sdaOut));
		reg_rd(8'h00, d);
		chk("pos reg", 8'h0A, {3'h0, d[4:0]});
		reg_rd(8'h01, d);
		chk("neg reg", 8'h0A, {3'h0, d[4:0]});
		reg_rd(8'h03, d);
		chk("ctrl reg", 8'h43, d & 8'h43);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			code = (i == 0) ? 8'h14 : (i == 1) ? 8'h15 : {3'h0, seed[4:0]};
			reg_wr({7'h00, i[0]}, {seed[7:5], code[4:0]});
			reg_rd({7'h00, i[0]}, d);
			chk("level reg", code, {3'h0, d[4:0]});
			chk("level out", lvl(code), 8'(i[0] ? negLevel : posLevel));
		end
		host.wr(bias_pkg::DEV_ADDR, 8'h00, 8'h03, 8'h11, 2, a);
		host.rd(8'h00, 2, d, e);
		chk("burst first", 8'h03, {3'h0, d[4:0]});
		chk("burst second", 8'h11, {3'h0, e[4:0]});
		host.wr(7'h12, 8'h00, 8'h1F, 8'h00, 1, a);
		chk("foreign address ack", 8'h00, 8'(a));
		wait_cyc(3);
		chk("level kept", 8'h03, 8'(posLevel));
		reg_wr(8'h02, 8'hFF);
		reg_rd(8'h02, d);
		chk("unmapped read", 8'h00, d);
		foreach (ctrlVals[i]) begin
			reg_wr(8'h03, ctrlVals[i]);
			reg_rd(8'h03, d);
			chk("ctrl bits", ctrlVals[i] & 8'h43, d & 8'h43);
			chk("app select", 8'(ctrlVals[i][6]), 8'(applicationSelect));
		end
		chk("clamp idle", 8'h00, softClamp);
		posRailEnable = 1'b1;
		negRailEnable = 1'b1;
		wait_cyc(20);
		chk("rails on", 8'h03, 8'({posRailOn, negRailOn}));
		chk("clamp ramping", 8'h01, 8'(softClamp > 8'h00 && softClamp < 8'hFF));
		wait_cyc(600);
		chk("clamp full", 8'hFF, softClamp);
		pwmOn = 1'b1;
		wait_cyc(6);
		chk("gate on", 8'h01, 8'(switchGate));
		overCurrent = 1'b1;
		wait_cyc(5);
		chk("gate cut", 8'h00, 8'(switchGate));
		overCurrent = 1'b0;
		wait_cyc(5);
		chk("gate held off", 8'h00, 8'(switchGate));
		pwmOn = 1'b0;
		wait_cyc(3);
		pwmOn = 1'b1;
		wait_cyc(6);
		chk("gate next period", 8'h01, 8'(switchGate));
		rail_off(1'b1, 1'b1);
		rail_off(1'b0, 1'b1);
		reg_wr(8'h03, 8'h40);
		rail_off(1'b1, 1'b0);
		rail_off(1'b0, 1'b0);
		negShortDet = 1'b1;
		wait_cyc(6);
		chk("neg limit", 8'h03, 8'({negCurrentLimit, negRailOn}));
		negShortDet = 1'b0;
		wait_cyc(6);
		chk("neg limit released", 8'h00, 8'(negCurrentLimit));
		posShortDet = 1'b1;
		wait_cyc(SHT - 10);
		posShortDet = 1'b0;
		wait_cyc(5);
		chk("brief short", 8'h03, 8'({posRailOn, negRailOn}));
		posShortDet = 1'b1;
		wait_cyc(SHT + 10);
		posShortDet = 1'b0;
		wait_cyc(20);
		chk("short latched", 8'h00, 8'({posRailOn, negRailOn}));
		posRailEnable = 1'b0;
		wait_cyc(5);
		posRailEnable = 1'b1;
		wait_cyc(10);
		chk("short cleared", 8'h03, 8'({posRailOn, negRailOn}));
		fault(1'b0);
		fault(1'b1);
		closeOut();
	end
endmodule

//--- dv/serial_host_model.sv
// host side of the two-wire register bus, clock at 125 ns per bit
// assumes the data line has a pull-up; the device only pulls it low
module serial_host_model (
	// device side
	input  wire logic sdaOe,
	// bus lines
	output logic      sclPin,
	output wire logic sdaLine
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam realtime Q = 31.25;
	logic hostLow;
	logic sampled;
	assign sdaLine = ~(hostLow | sdaOe);
	initial begin
		sclPin = 1'b1;
		hostLow = 1'b0;
		sampled = 1'b1;
	end
	// data moves only while the clock is low
	task automatic clk_bit(input logic b);
		hostLow = ~b;
		#Q sclPin = 1'b1;
		#Q sampled = sdaLine;
		#Q sclPin = 1'b0;
		#Q;
	endtask
	task automatic frame_start(input logic again);
		if (again) begin
			hostLow = 1'b0;
			#Q sclPin = 1'b1;
			#Q;
		end
		hostLow = 1'b1;
		#Q sclPin = 1'b0;
		#Q;
	endtask
	task automatic frame_stop();
		hostLow = 1'b1;
		#Q sclPin = 1'b1;
		#Q hostLow = 1'b0;
		#(2 * Q);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i]);
		clk_bit(1'b1);
		ack = ~sampled;
	endtask
	// last byte gets no acknowledge
	task automatic recv(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1);
			d[i] = sampled;
		end
		clk_bit(last);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d0,
			input logic [7:0] d1, input int n, output logic acks);
		logic a;
		frame_start(1'b0);
		send({dev, 1'b0}, acks);
		send(ra, a);
		acks &= a;
		send(d0, a);
		acks &= a;
		if (n > 1)
			send(d1, a);
		frame_stop();
	endtask
	task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] d0,
			output logic [7:0] d1);
		logic a;
		d1 = 8'h00;
		frame_start(1'b0);
		send({bias_pkg::DEV_ADDR, 1'b0}, a);
		send(ra, a);
		frame_start(1'b1);
		send({bias_pkg::DEV_ADDR, 1'b1}, a);
		recv(n == 1, d0);
		if (n > 1)
			recv(1'b1, d1);
		frame_stop();
	endtask
endmodule

//--- hdl/bias_pkg.sv
// constants for the display bias control block
// assumes a 125 MHz system clock
package bias_pkg;
	localparam int CLK_MHZ        = 125;
	localparam int OFF_DELAY_US   = 375;
	localparam int OFF_DELAY_CYC  = OFF_DELAY_US * CLK_MHZ;
	localparam int DISCH_MS       = 20;
	localparam int DISCH_CYC      = DISCH_MS * 1000 * CLK_MHZ;
	localparam int SHORT_MS       = 1;
	localparam int SHORT_CYC      = SHORT_MS * 1000 * CLK_MHZ;
	localparam int SS_TIME_US     = 1000;
	localparam int SS_STEP_CYC    = (SS_TIME_US * CLK_MHZ) / 256;
	localparam int CNT_W          = 22;
	typedef logic [CNT_W-1:0] cnt_t;
	localparam logic [6:0] DEV_ADDR     = 7'h73;
	localparam logic [7:0] POS_LVL_OFS  = 8'h00;
	localparam logic [7:0] NEG_LVL_OFS  = 8'h01;
	localparam logic [7:0] CTRL_OFS     = 8'h03;
	localparam logic [4:0] LVL_RESET    = 5'h0A;
	localparam logic [4:0] LVL_MAX      = 5'h14;
	localparam logic [7:0] CTRL_RESET   = 8'h43;
	localparam int         APP_BIT      = 6;
	localparam int         POS_DIS_BIT  = 1;
	localparam int         NEG_DIS_BIT  = 0;
endpackage

//--- hdl/lcd_bias_control.sv
// register bank and sequencing for a dual-rail display bias supply
// assumes pins and analogue indications are asynchronous to mclk
// What this block does
// - The negative rail level is a 5-bit code from -4 V in 0.1 V steps, code 0x14 being -6 V.
// - Control bit 1 at offset 0x03 enables timed discharge of the positive rail.
// - Control bit 0 at offset 0x03 enables timed discharge of the negative rail.
// - Reserved bits ignore writes and read back as zero here.
// - Reset values are 0x0A for both levels and 0x43 for control, bit 6 picking smartphone use.
// - A rail turns off only after its enable has been low for more than 375 us.
// - With discharge enabled, a rail that turns off is pulled to ground for 20 ms, then floats.
// - A positive rail held in short for 1 ms latches shutdown until an enable rises again.
// - A negative rail short only holds current limit and recovers by itself.
// - Over-temperature stops both rails until the indication drops.
// - The switch is forced off for the rest of an on-period once over-current is seen.
// - Undervoltage lockout holds both rails in shutdown.
// - The regulation clamp ramps from zero to full scale after start-up.
// - The positive rail level is a 5-bit code at offset 0x00 from 4 V, code 0x14 being 6 V.
// - Registers are reached over the two-wire bus: address, register pointer, data, or read.
module lcd_bias_control #(
	parameter int OFF_CYC   = bias_pkg::OFF_DELAY_CYC,
	parameter int DISCH_CYC = bias_pkg::DISCH_CYC,
	parameter int SHORT_CYC = bias_pkg::SHORT_CYC,
	parameter int SS_STEP   = bias_pkg::SS_STEP_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// serial bus pins
	input  wire logic       sclPin,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// enable pins
	input  wire logic       posRailEnable,
	input  wire logic       negRailEnable,
	// analogue indications
	input  wire logic       posShortDet,
	input  wire logic       negShortDet,
	input  wire logic       overTemp,
	input  wire logic       overCurrent,
	input  wire logic       uvloDet,
	input  wire logic       pwmOn,
	// analogue controls
	output logic [4:0]      posLevel,
	output logic [4:0]      negLevel,
	output logic            applicationSelect,
	output logic            posRailOn,
	output logic            negRailOn,
	output logic            posDischargeOn,
	output logic            negDischargeOn,
	output logic            negCurrentLimit,
	output logic            switchGate,
	output logic [7:0]      softClamp
);
	reg_access_if bus ();
	logic [6:0]     meta_reg, sync_reg;
	logic [1:0]     enS, enPrev_reg, enOn_reg, railOn_reg, disch_reg, active, dBit;
	logic           posShortS, negShortS, overTempS, ocS, uvloS, run;
	bias_pkg::cnt_t offCnt_reg [2];
	bias_pkg::cnt_t dischCnt_reg [2];
	bias_pkg::cnt_t shortCnt_reg, ssCnt_reg;
	logic [4:0]     posCode_reg, negCode_reg;
	logic           app_reg, dP_reg, dN_reg, latch_reg, ocHold_reg;
	logic [7:0]     rdata_reg;

	function automatic logic [4:0] clampCode(input logic [4:0] c);
		clampCode = (c > bias_pkg::LVL_MAX) ? bias_pkg::LVL_MAX : c;
	endfunction

	serial_reg_slave u_slave (
		.mclk   (mclk),
		.rst    (rst),
		.sclPin (sclPin),
		.sdaIn  (sdaIn),
		.sdaOe  (sdaOe),
		.bus    (bus.front)
	);
	// open drain: only ever pulls low
	assign sdaOut = 1'b0;

	// two-stage synchronisers
	always_ff @(posedge mclk) begin
		meta_reg <= {posRailEnable, negRailEnable, posShortDet, negShortDet,
			overTemp, overCurrent, uvloDet};
		sync_reg <= meta_reg;
	end
	assign enS       = {sync_reg[5], sync_reg[6]};
	assign posShortS = sync_reg[4];
	assign negShortS = sync_reg[3];
	assign overTempS = sync_reg[2];
	assign ocS       = sync_reg[1];
	assign uvloS     = sync_reg[0];

	// register writes; reserved bits dropped
	always_ff @(posedge mclk) begin
		if (rst) begin
			posCode_reg <= bias_pkg::LVL_RESET;
			negCode_reg <= bias_pkg::LVL_RESET;
			app_reg     <= bias_pkg::CTRL_RESET[bias_pkg::APP_BIT];
			dP_reg      <= bias_pkg::CTRL_RESET[bias_pkg::POS_DIS_BIT];
			dN_reg      <= bias_pkg::CTRL_RESET[bias_pkg::NEG_DIS_BIT];
		end else if (bus.wrStb) begin
			if (bus.addr == bias_pkg::POS_LVL_OFS)
				posCode_reg <= bus.wdata[4:0];
			else if (bus.addr == bias_pkg::NEG_LVL_OFS)
				negCode_reg <= bus.wdata[4:0];
			else if (bus.addr == bias_pkg::CTRL_OFS) begin
				app_reg <= bus.wdata[bias_pkg::APP_BIT];
				dP_reg  <= bus.wdata[bias_pkg::POS_DIS_BIT];
				dN_reg  <= bus.wdata[bias_pkg::NEG_DIS_BIT];
			end
		end
	end

	// read data; unmapped and reserved read as zero
	always_ff @(posedge mclk) begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (bus.addr == bias_pkg::POS_LVL_OFS)
			rdata_reg <= {3'h0, posCode_reg};
		else if (bus.addr == bias_pkg::NEG_LVL_OFS)
			rdata_reg <= {3'h0, negCode_reg};
		else if (bus.addr == bias_pkg::CTRL_OFS)
			rdata_reg <= {1'b0, app_reg, 4'h0, dP_reg, dN_reg};
		else
			rdata_reg <= 8'h00;
	end
	assign bus.rdata = rdata_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			posLevel          <= bias_pkg::LVL_RESET;
			negLevel          <= bias_pkg::LVL_RESET;
			applicationSelect <= bias_pkg::CTRL_RESET[bias_pkg::APP_BIT];
		end else begin
			posLevel          <= clampCode(posCode_reg);
			negLevel          <= clampCode(negCode_reg);
			applicationSelect <= app_reg;
		end
	end

	// enable filter and discharge timing, index 0 positive, 1 negative
	assign run    = !latch_reg && !overTempS && !uvloS;
	assign active = enOn_reg & {run, run};
	assign dBit   = {dN_reg, dP_reg};

	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				enOn_reg[i]     <= 1'b0;
				offCnt_reg[i]   <= '0;
				railOn_reg[i]   <= 1'b0;
				disch_reg[i]    <= 1'b0;
				dischCnt_reg[i] <= '0;
			end else begin
				if (enS[i]) begin
					enOn_reg[i]   <= 1'b1;
					offCnt_reg[i] <= '0;
				end else if (offCnt_reg[i] == bias_pkg::cnt_t'(OFF_CYC))
					enOn_reg[i] <= 1'b0;
				else
					offCnt_reg[i] <= offCnt_reg[i] + 1'b1;
				railOn_reg[i] <= active[i];
				if (active[i])
					disch_reg[i] <= 1'b0;
				else if (railOn_reg[i]) begin
					disch_reg[i]    <= dBit[i];
					dischCnt_reg[i] <= '0;
				end else if (disch_reg[i]) begin
					if (dischCnt_reg[i] == bias_pkg::cnt_t'(DISCH_CYC - 1))
						disch_reg[i] <= 1'b0;
					else
						dischCnt_reg[i] <= dischCnt_reg[i] + 1'b1;
				end
			end
		end
	end
	assign posRailOn      = railOn_reg[0];
	assign negRailOn      = railOn_reg[1];
	assign posDischargeOn = disch_reg[0];
	assign negDischargeOn = disch_reg[1];

	// positive short latch; a new enable rise clears, a new set wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			enPrev_reg   <= 2'h0;
			shortCnt_reg <= '0;
			latch_reg    <= 1'b0;
		end else begin
			enPrev_reg <= enS;
			if (!(posShortS && railOn_reg[0]))
				shortCnt_reg <= '0;
			else if (shortCnt_reg != bias_pkg::cnt_t'(SHORT_CYC - 1))
				shortCnt_reg <= shortCnt_reg + 1'b1;
			if (posShortS && railOn_reg[0] &&
				shortCnt_reg == bias_pkg::cnt_t'(SHORT_CYC - 1))
				latch_reg <= 1'b1;
			else if (|(enS & ~enPrev_reg))
				latch_reg <= 1'b0;
		end
	end

	// negative short: current limit only
	always_ff @(posedge mclk) begin
		if (rst)
			negCurrentLimit <= 1'b0;
		else
			negCurrentLimit <= negShortS && railOn_reg[1];
	end

	// cycle-by-cycle switch cut-off
	always_ff @(posedge mclk) begin
		if (rst) begin
			ocHold_reg <= 1'b0;
			switchGate <= 1'b0;
		end else begin
			if (!pwmOn)
				ocHold_reg <= 1'b0;
			else if (ocS)
				ocHold_reg <= 1'b1;
			switchGate <= pwmOn && !ocS && !ocHold_reg && |railOn_reg;
		end
	end

	// soft-start ramp of the regulation clamp
	always_ff @(posedge mclk) begin
		if (rst || !(|railOn_reg)) begin
			softClamp <= 8'h00;
			ssCnt_reg <= '0;
		end else if (softClamp != 8'hFF) begin
			if (ssCnt_reg == bias_pkg::cnt_t'(SS_STEP - 1)) begin
				ssCnt_reg <= '0;
				softClamp <= softClamp + 8'h01;
			end else
				ssCnt_reg <= ssCnt_reg + 1'b1;
		end
	end

	AST_NEG_CODE_MAX: assert property (@(posedge mclk) disable iff (rst)
		negLevel <= bias_pkg::LVL_MAX && (negLevel == clampCode($past(negCode_reg))))
		else $error("negative level code out of range or stale");
	AST_POS_DIS_WRITE: assert property (@(posedge mclk) disable iff (rst)
		bus.wrStb && bus.addr == bias_pkg::CTRL_OFS |=> dP_reg == $past(bus.wdata[1]))
		else $error("positive discharge bit not written");
	AST_NEG_DIS_WRITE: assert property (@(posedge mclk) disable iff (rst)
		bus.wrStb && bus.addr == bias_pkg::CTRL_OFS |=> dN_reg == $past(bus.wdata[0]))
		else $error("negative discharge bit not written");
	AST_RSVD_WRITE: assert property (@(posedge mclk) disable iff (rst)
		bus.wrStb && bus.addr != bias_pkg::POS_LVL_OFS && bus.addr != bias_pkg::NEG_LVL_OFS &&
		bus.addr != bias_pkg::CTRL_OFS |=>
		$stable({posCode_reg, negCode_reg, app_reg, dP_reg, dN_reg}))
		else $error("write to unmapped register changed state");
	AST_RESET_VAL: assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> posCode_reg == 5'h0A && negCode_reg == 5'h0A && app_reg && dP_reg && dN_reg)
		else $error("register reset value wrong");
	AST_OFF_DELAY: assert property (@(posedge mclk) disable iff (rst)
		$fell(enOn_reg[0]) |-> !enS[0] && $past(offCnt_reg[0]) == bias_pkg::cnt_t'(OFF_CYC))
		else $error("positive enable filtered off too early");
	AST_DISCH_LEN: assert property (@(posedge mclk) disable iff (rst)
		$fell(posDischargeOn) && !posRailOn |->
		$past(dischCnt_reg[0]) == bias_pkg::cnt_t'(DISCH_CYC - 1))
		else $error("discharge pulse length wrong");
	AST_SHORT_LATCH: assert property (@(posedge mclk) disable iff (rst)
		$rose(latch_reg) |-> $past(shortCnt_reg) == bias_pkg::cnt_t'(SHORT_CYC - 1) ##1 !posRailOn)
		else $error("short latch timing wrong");
	AST_NEG_LIMIT: assert property (@(posedge mclk) disable iff (rst)
		negShortS && negRailOn |=> negCurrentLimit && !latch_reg)
		else $error("negative short handling wrong");
	AST_OTP_OFF: assert property (@(posedge mclk) disable iff (rst)
		overTempS || uvloS |=> !posRailOn && !negRailOn)
		else $error("rail stayed on under fault");
	AST_OC_CUT: assert property (@(posedge mclk) disable iff (rst)
		ocS && pwmOn |=> !switchGate ##1 (!switchGate || !$past(pwmOn)))
		else $error("switch not forced off on over-current");
	AST_SS_RAMP: assert property (@(posedge mclk) disable iff (rst)
		|railOn_reg && $past(|railOn_reg) |->
		softClamp == $past(softClamp) || softClamp == $past(softClamp) + 8'h01)
		else $error("soft-start clamp jumped");
	AST_NO_DISCH: assert property (@(posedge mclk) disable iff (rst)
		$fell(posRailOn) && !dP_reg |-> !posDischargeOn)
		else $error("discharge while disabled");
endmodule

//--- hdl/reg_access_if.sv
// register access between the serial front end and the register bank
// assumes one clock; wrStb is a single-cycle pulse
interface reg_access_if;
	logic       wrStb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport front (output wrStb, output addr, output wdata, input rdata);
	modport bank  (input wrStb, input addr, input wdata, output rdata);
endinterface

//--- hdl/serial_reg_slave.sv
// two-wire serial register slave, open-drain data line
// assumes scl and sda arrive asynchronously; sampled on mclk
module serial_reg_slave (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// pins
	input  wire logic sclPin,
	input  wire logic sdaIn,
	output logic      sdaOe,
	// register side
	reg_access_if.front bus
);
	typedef enum {IDLE, DEVADDR, REGADDR, WRDATA, ACKOUT, RDDATA, ACKIN} sstate_t;
	sstate_t    state_reg, after_reg;
	logic [1:0] sclMeta_reg, sdaMeta_reg;
	logic       sclS_reg, sdaS_reg, sclPrev_reg, sdaPrev_reg;
	logic [7:0] shift_reg, ptr_reg, wdata_reg;
	logic [3:0] bitCnt_reg;
	logic       wrStb_reg, nack_reg;
	logic       sclRise, sclFall, startCond, stopCond;

	always_ff @(posedge mclk) begin
		sclMeta_reg <= {sclMeta_reg[0], sclPin};
		sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
		sclS_reg    <= sclMeta_reg[1];
		sdaS_reg    <= sdaMeta_reg[1];
		sclPrev_reg <= sclS_reg;
		sdaPrev_reg <= sdaS_reg;
	end

	assign sclRise   = sclS_reg & ~sclPrev_reg;
	assign sclFall   = ~sclS_reg & sclPrev_reg;
	assign startCond = sclS_reg & sclPrev_reg & sdaPrev_reg & ~sdaS_reg;
	assign stopCond  = sclS_reg & sclPrev_reg & ~sdaPrev_reg & sdaS_reg;

	// device address, register address, data; reads after repeated start
	always_ff @(posedge mclk) begin
		wrStb_reg <= 1'b0;
		if (rst) begin
			state_reg  <= IDLE;
			after_reg  <= IDLE;
			sdaOe      <= 1'b0;
			bitCnt_reg <= 4'h0;
			shift_reg  <= 8'h00;
			wdata_reg  <= 8'h00;
			ptr_reg    <= 8'h00;
			nack_reg   <= 1'b0;
		end else if (startCond) begin
			state_reg  <= DEVADDR;
			bitCnt_reg <= 4'h0;
			sdaOe      <= 1'b0;
		end else if (stopCond) begin
			state_reg <= IDLE;
			sdaOe     <= 1'b0;
		end else begin
			if (wrStb_reg)
				ptr_reg <= ptr_reg + 8'h01;
			case (state_reg)
				DEVADDR, REGADDR, WRDATA: begin
					if (sclRise) begin
						shift_reg  <= {shift_reg[6:0], sdaS_reg};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (sclFall && bitCnt_reg == 4'h8) begin
						bitCnt_reg <= 4'h0;
						state_reg  <= ACKOUT;
						sdaOe      <= 1'b1;
						if (state_reg == DEVADDR) begin
							if (shift_reg[7:1] != bias_pkg::DEV_ADDR) begin
								state_reg <= IDLE;
								sdaOe     <= 1'b0;
							end
							after_reg <= shift_reg[0] ? RDDATA : REGADDR;
						end else if (state_reg == REGADDR) begin
							ptr_reg   <= shift_reg;
							after_reg <= WRDATA;
						end else begin
							wrStb_reg <= 1'b1;
							wdata_reg <= shift_reg;
							after_reg <= WRDATA;
						end
					end
				end
				ACKOUT: begin
					if (sclFall) begin
						state_reg <= after_reg;
						sdaOe     <= 1'b0;
						if (after_reg == RDDATA) begin
							shift_reg <= bus.rdata;
							sdaOe     <= ~bus.rdata[7];
							ptr_reg   <= ptr_reg + 8'h01;
						end
					end
				end
				RDDATA: begin
					if (sclFall) begin
						bitCnt_reg <= bitCnt_reg + 4'h1;
						shift_reg  <= {shift_reg[6:0], 1'b0};
						sdaOe      <= ~shift_reg[6];
						if (bitCnt_reg == 4'h7) begin
							state_reg  <= ACKIN;
							sdaOe      <= 1'b0;
							bitCnt_reg <= 4'h0;
						end
					end
				end
				ACKIN: begin
					if (sclRise)
						nack_reg <= sdaS_reg;
					else if (sclFall) begin
						if (nack_reg)
							state_reg <= IDLE;
						else begin
							state_reg <= RDDATA;
							shift_reg <= bus.rdata;
							sdaOe     <= ~bus.rdata[7];
							ptr_reg   <= ptr_reg + 8'h01;
						end
					end
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	assign bus.wrStb = wrStb_reg;
	assign bus.addr  = ptr_reg;
	assign bus.wdata = wdata_reg;

	AST_WR_ONE_PULSE: assert property (@(posedge mclk) disable iff (rst)
		bus.wrStb |=> !bus.wrStb && bus.addr == $past(bus.addr) + 8'h01)
		else $error("write strobe not single or pointer not advanced");
endmodule
